// File: hdl/odl_params.svh
`ifndef ODL_PARAMS_SVH
`define ODL_PARAMS_SVH

`define ODL_WORD_W      12
`define ODL_ADDR_W      4
`define ODL_CODE_W      8
`define ODL_CHANNELS    8
`define ODL_CH_W        3
`define ODL_SYNC_W      2
`define ODL_ADDR_MSB    11
`define ODL_ADDR_LSB    8
`define ODL_CODE_MSB    7
`define ODL_PRESET_CODE 8'h80
`define ODL_ADDR_FIRST  4'h1
`define ODL_ADDR_LAST   4'h8

`endif

// File: hdl/odl_pkg.sv
`include "odl_params.svh"

package odl_pkg;

  typedef logic [`ODL_CHANNELS-1:0][`ODL_CODE_W-1:0] odl_codes_t;

  typedef struct packed {
    logic                  hit;
    logic [`ODL_CH_W-1:0]  ch;
  } odl_sel_t;

  typedef struct packed {
    logic [`ODL_SYNC_W-1:0] sclk_sync;
    logic [`ODL_SYNC_W-1:0] sin_sync;
    logic [`ODL_SYNC_W-1:0] ld_sync;
    logic [`ODL_SYNC_W-1:0] pre_sync;
    logic                   sclk_prev;
    logic                   ld_prev;
    logic [`ODL_WORD_W-1:0] shift;
    logic                   sout;
    odl_codes_t             codes;
  } odl_state_t;

endpackage : odl_pkg

// File: hdl/odl_serial_load.sv
`timescale 1ns/10ps
`include "odl_params.svh"

module odl_serial_load
  import odl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       serial_clk_i,
  input  wire logic       serial_in_i,
  input  wire logic       load_strobe_i,
  input  wire logic       preset_n_i,
  output logic            serial_out_o,
  output odl_codes_t      code_o
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic odl_sel_t odl_decode(input logic [`ODL_ADDR_W-1:0] addr);
    odl_sel_t sel;
    logic [`ODL_ADDR_W-1:0] offs;
    offs     = addr - `ODL_ADDR_FIRST;
    sel.hit  = (addr >= `ODL_ADDR_FIRST) && (addr <= `ODL_ADDR_LAST);
    sel.ch   = offs[`ODL_CH_W-1:0];
    return sel;
  endfunction : odl_decode

  function automatic odl_codes_t odl_ch_mask(input logic [`ODL_CH_W-1:0] ch);
    odl_codes_t mask;
    mask     = '0;
    mask[ch] = '1;
    return mask;
  endfunction : odl_ch_mask

  // ----------------------------------------
  // State
  // ----------------------------------------
  odl_state_t state;
  odl_state_t next_state;
  logic       sclk_rise;
  logic       ld_rise;
  logic       preset_on;
  logic       sin;
  odl_sel_t   sel;
  logic       shift_ok;
  logic       load_ok;

  // ----------------------------------------
  // Edge detect and qualifiers
  // ----------------------------------------
  assign sclk_rise = state.sclk_sync[1] & ~state.sclk_prev;
  assign ld_rise   = state.ld_sync[1] & ~state.ld_prev;
  assign preset_on = ~state.pre_sync[1];
  assign sin       = state.sin_sync[1];
  assign sel       = odl_decode(state.shift[`ODL_ADDR_MSB:`ODL_ADDR_LSB]);
  assign shift_ok  = sclk_rise && !state.ld_sync[1] && !preset_on;
  assign load_ok   = ld_rise && !preset_on;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_state           = state;
    next_state.sclk_sync = {state.sclk_sync[0], serial_clk_i};
    next_state.sin_sync  = {state.sin_sync[0], serial_in_i};
    next_state.ld_sync   = {state.ld_sync[0], load_strobe_i};
    next_state.pre_sync  = {state.pre_sync[0], preset_n_i};
    next_state.sclk_prev = state.sclk_sync[1];
    next_state.ld_prev   = state.ld_sync[1];
    if (shift_ok)
    begin
      next_state.sout  = state.shift[`ODL_WORD_W-1];
      next_state.shift = {state.shift[`ODL_WORD_W-2:0], sin};
    end
    if (preset_on)
    begin
      for (int i = 0; i < `ODL_CHANNELS; i++)
      begin
        next_state.codes[i] = `ODL_PRESET_CODE;
      end
    end
    else if (ld_rise && sel.hit)
    begin
      next_state.codes[sel.ch] = state.shift[`ODL_CODE_MSB:0];
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state           <= '0;
      state.pre_sync  <= '1;
      for (int i = 0; i < `ODL_CHANNELS; i++)
      begin
        state.codes[i] <= `ODL_PRESET_CODE;
      end
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign serial_out_o = state.sout;
  assign code_o       = state.codes;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // Check helpers
  // ----------------------------------------
  logic [`ODL_ADDR_W-1:0] load_addr;
  logic [`ODL_CH_W-1:0]   load_ch;
  logic                   load_hit;
  odl_codes_t             load_mask;

  assign load_addr = state.shift[`ODL_ADDR_MSB:`ODL_ADDR_LSB];
  assign load_ch   = load_addr[`ODL_CH_W-1:0] - `ODL_CH_W'(`ODL_ADDR_FIRST);
  assign load_hit  = (load_addr != '0) && (load_addr <= `ODL_ADDR_LAST);
  assign load_mask = odl_ch_mask(load_ch);

  shift_edge_only_a: assert property (!sclk_rise |=> $stable(state.shift))
    else $error("shift moved without a serial clock rise");

  shift_data_a: assert property (
    shift_ok |=> state.shift == {$past(state.shift[`ODL_WORD_W-2:0]), $past(sin)})
    else $error("shift did not take the serial input bit");

  hold_load_a: assert property ((state.ld_sync[1] || preset_on) |=> $stable(state.shift))
    else $error("shift moved while strobe high or preset active");

  load_write_a: assert property (
    (load_ok && sel.hit) |=> code_o[$past(sel.ch)] == $past(state.shift[`ODL_CODE_MSB:0]))
    else $error("addressed channel not written on strobe rise");

  load_edge_a: assert property ((!ld_rise && !preset_on) |=> $stable(code_o))
    else $error("codes changed without a strobe rise");

  nop_hold_a: assert property ((ld_rise && !sel.hit) && !preset_on |=> $stable(code_o))
    else $error("no-operation address changed a channel");

  preset_force_a: assert property (preset_on |=> code_o == {`ODL_CHANNELS{`ODL_PRESET_CODE}})
    else $error("preset did not force half scale");

  sout_delay_a: assert property (
    shift_ok |=> serial_out_o == $past(state.shift[`ODL_WORD_W-1]))
    else $error("serial out not the twelve-edge delayed bit");

  sout_stable_a: assert property (!sclk_rise |=> $stable(serial_out_o))
    else $error("serial out changed without a serial clock rise");

  // ----------------------------------------
  // Decode and hold checks
  // ----------------------------------------
  addr_map_a: assert property (
    (load_ok && load_hit) |=> code_o[$past(load_ch)] == $past(state.shift[`ODL_CODE_MSB:0]))
    else $error("address did not select its own channel");

  other_hold_a: assert property (
    (load_ok && load_hit) |=> ((code_o ^ $past(code_o)) & ~$past(load_mask)) == '0)
    else $error("load disturbed another channel");

  nop_zero_a: assert property (
    (load_ok && (load_addr == '0)) |=> $stable(code_o))
    else $error("all-zeros address changed a channel");

  nop_range_a: assert property (
    (load_ok && (load_addr > `ODL_ADDR_LAST)) |=> $stable(code_o))
    else $error("high no-operation address changed a channel");

  decode_hit_a: assert property (
    sel.hit == load_hit)
    else $error("address decode hit mismatch");

  decode_chan_a: assert property (
    sel.hit |-> (sel.ch == load_ch))
    else $error("address decode channel mismatch");

  strobe_level_a: assert property (
    (state.ld_sync[1] && state.ld_prev && !preset_on) |=> $stable(code_o))
    else $error("held strobe reloaded a channel");

  sout_refuse_a: assert property (
    (state.ld_sync[1] || preset_on) |=> $stable(serial_out_o))
    else $error("serial out moved while strobe high or preset active");

  level_no_shift_a: assert property (
    (state.sclk_sync[1] == state.sclk_prev) |=> $stable(state.shift))
    else $error("shift moved on a steady serial clock");

  fall_no_shift_a: assert property (
    (!state.sclk_sync[1] && state.sclk_prev) |=> $stable(state.shift))
    else $error("shift moved on a serial clock fall");

endmodule : odl_serial_load

// File: test/odl_host_model.sv
`timescale 1ns/10ps
module odl_host_model (
  input  wire logic clk_i,
  output logic      sclk_o,
  output logic      sdata_o,
  output logic      load_o
);
  initial
  begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    load_o = 1'b0;
  end
  // Words MSB first, clock idles low, 320 ns period
  task automatic send(input logic [35:0] w, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      sdata_o = w[i];
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    sdata_o = ~sdata_o;
  endtask : send
  // Strobe after last rise, before any further rise
  task automatic strobe();
    repeat (4) @(negedge clk_i);
    load_o = 1'b1;
    repeat (4) @(negedge clk_i);
    load_o = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask : strobe
  // Hold the strobe level across a transfer
  task automatic hold_strobe(input logic lvl);
    load_o = lvl;
  endtask : hold_strobe
endmodule : odl_host_model

// File: test/odl_serial_load_tb.sv
`timescale 1ns/10ps
module odl_serial_load_tb;
  import odl_pkg::*;
  logic        clk_i, rst_i, preset_n_i, sclk, sdata, load, serial_out_o;
  odl_codes_t  code_o, exp;
  int          num_errors, checks;
  typedef struct packed {
    logic [11:0] word;
    logic        hit;
    logic [2:0]  ch;
    logic        sout;
  } odl_row_t;
  // Word, then expected hit, channel and serial out
  odl_row_t    rows [11] = '{{12'h1ff, 1'b1, 3'h0, 1'b0}, {12'h800, 1'b1, 3'h7, 1'b1},
                             {12'h27f, 1'b1, 3'h1, 1'b0}, {12'h381, 1'b1, 3'h2, 1'b1},
                             {12'h4a5, 1'b1, 3'h3, 1'b1}, {12'h55a, 1'b1, 3'h4, 1'b1},
                             {12'h6c3, 1'b1, 3'h5, 1'b0}, {12'h73c, 1'b1, 3'h6, 1'b1},
                             {12'h0ee, 1'b0, 3'h0, 1'b0}, {12'h911, 1'b0, 3'h0, 1'b0},
                             {12'hf22, 1'b0, 3'h0, 1'b1}};
  odl_host_model u_host (.clk_i(clk_i), .sclk_o(sclk), .sdata_o(sdata), .load_o(load));
  odl_serial_load u_odl_serial_load (.clk_i(clk_i), .rst_i(rst_i), .serial_clk_i(sclk),
    .serial_in_i(sdata), .load_strobe_i(load), .preset_n_i(preset_n_i),
    .serial_out_o(serial_out_o), .code_o(code_o));
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] want);
    checks++;
    if (seen !== want)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial
  begin
    #500000;
    num_errors++;
    finish_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst_i = 1'b1;
    preset_n_i = 1'b1;
    exp = {8{8'h80}};
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    check("reset codes", code_o, exp);
    check("reset sout", {63'h0, serial_out_o}, 64'h0);
    $display("test reset done");
    foreach (rows[i])
    begin
      u_host.send({24'h0, rows[i].word}, 12);
      check("sout delay", {63'h0, serial_out_o}, {63'h0, rows[i].sout});
      u_host.strobe();
      if (rows[i].hit)
        exp[rows[i].ch] = rows[i].word[7:0];
      check("codes", code_o, exp);
    end
    $display("test rows done");
    u_host.send({12'h2c1, 12'h0e1, 12'h512}, 36);
    check("chain sout", {63'h0, serial_out_o}, 64'h1);
    u_host.strobe();
    exp[4] = 8'h12;
    check("chain codes", code_o, exp);
    $display("test chain done");
    u_host.hold_strobe(1'b1);
    u_host.send({24'h0, 12'h3aa}, 12);
    u_host.hold_strobe(1'b0);
    u_host.strobe();
    check("blocked shift", code_o, exp);
    $display("test block done");
    preset_n_i = 1'b0;
    u_host.strobe();
    check("preset codes", code_o, {8{8'h80}});
    $display("test preset done");
    preset_n_i = 1'b1;
    exp = {8{8'h80}};
    u_host.send({24'h0, 12'h2c3}, 12);
    u_host.strobe();
    exp[1] = 8'hc3;
    check("release codes", code_o, exp);
    rst_i = 1'b1;
    @(negedge clk_i);
    check("mid reset codes", code_o, {8{8'h80}});
    repeat (7) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    u_host.send({24'h0, 12'h3aa}, 12);
    check("mid reset sout", {63'h0, serial_out_o}, 64'h0);
    u_host.strobe();
    exp = {8{8'h80}};
    exp[2] = 8'haa;
    check("mid reset load", code_o, exp);
    $display("test mid reset done");
    finish_test();
  end
endmodule : odl_serial_load_tb
